// File: scd_pkg.sv
package scd_pkg;

  localparam int          ADDR_W       = 16;
  localparam logic [15:0] CLKDIV1_OFS  = 16'h1044;
  localparam int          CORE_LSB     = 28;
  localparam int          CORE_W       = 4;
  localparam int          BUS_LSB      = 16;
  localparam int          BUS_W        = 3;
  localparam logic [2:0]  BUS_RST      = 3'h1;
  localparam logic [31:0] RSV_MASK     = 32'h0FF8FFFF;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int          CORE_LANE    = 3;
  localparam int          BUS_LANE     = 2;

  typedef struct packed {
    logic [3:0]  core;
    logic [8:0]  rsv_hi;
    logic [2:0]  bus;
    logic [15:0] rsv_lo;
  } scd_clkdiv1_t;

  // boot option to core/system code: 0, 1, 3 or 7 (divide by 1, 2, 4 or 8)
  function automatic logic [3:0] scd_boot_code(input logic [1:0] opt);
    case (opt)
      2'h0:    scd_boot_code = 4'h0;
      2'h1:    scd_boot_code = 4'h1;
      2'h2:    scd_boot_code = 4'h3;
      default: scd_boot_code = 4'h7;
    endcase
  endfunction : scd_boot_code

  function automatic logic scd_hit(input logic [15:0] addr);
    scd_hit = (addr[15:2] == CLKDIV1_OFS[15:2]);
  endfunction : scd_hit

endpackage : scd_pkg

// File: scd_div.sv
`timescale 1ns/1ns
`default_nettype none
module scd_div #(
  parameter int W = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] ratio,
  output logic              tick_out
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] act_r;
  logic         tick_r;
  logic         wrap;

  assign wrap     = tick_in && (cnt_r == act_r);
  assign tick_out = tick_r;

  // new ratio taken only at a period boundary
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      act_r <= '0;
    end else if (ce && tick_in) begin
      cnt_r <= wrap ? '0 : W'(cnt_r + 1'b1);
      if (wrap) begin
        act_r <= ratio;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_r <= 1'b0;
    end else if (ce) begin
      tick_r <= tick_in && (cnt_r == '0);
    end
  end

  sequence s_wrap;
    ce && tick_in && (cnt_r == act_r);
  endsequence

  sequence s_start;
    ce && tick_in && (cnt_r == '0);
  endsequence

  a_period_wraps_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wrap |=> (cnt_r == '0))
    else $error("divider count did not restart after period wrap");

  a_start_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    s_start |=> tick_r)
    else $error("divided tick missing at period start");

  a_count_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_r <= act_r)
    else $error("divider count passed its ratio");

  a_ratio_switch_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    (act_r != $past(act_r)) |-> $past(wrap) && $past(ce))
    else $error("ratio changed inside a period");

endmodule : scd_div
`default_nettype wire

// File: scd_top.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - a register write made while very_low_power_run is high leaves both ratios unchanged.
// - every system reset reloads the register, the core/system field from the boot option.
// - after reset the core/system field holds 0000, 0001, 0011 or 0111 per the two boot bits.
// - the core/system field divides core/system and bus/flash clocks by value plus one, 1 to 16.
// - the bus/flash field further divides the bus/flash clock by value plus one, 1 to 8.
// - after reset the bus/flash field holds 001, divide by two.
// - reserved bits 27 to 19 and 15 to 0 read as zero and cannot be written.
module scd_top
  import scd_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [1:0]        low_power_boot_option,
  input  wire logic              very_low_power_run,
  output logic                   core_clk_en,
  output logic                   bus_flash_clk_en
);

  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              aw_got_r;
  logic              w_got_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;
  logic [3:0]        core_div_r;
  logic [2:0]        bus_div_r;
  logic              wr_do;
  logic              b_done;
  logic              ar_take;
  logic              core_tick;
  scd_clkdiv1_t      view;

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  assign wr_do   = aw_got_r && w_got_r && !bvalid_r;
  assign b_done  = bvalid_r && s_axi_bready;
  assign ar_take = s_axi_arvalid && arready_r;

  // read view, reserved fields forced low
  always_comb begin
    view        = '0;
    view.core   = core_div_r;
    view.bus    = bus_div_r;
  end

  // write address and data, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      awready_r <= 1'b1;
      awaddr_r  <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_r) begin
        aw_got_r  <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r  <= s_axi_awaddr;
      end else if (b_done) begin
        aw_got_r  <= 1'b0;
        awready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r  <= 1'b0;
      wready_r <= 1'b1;
      wdata_r  <= '0;
      wstrb_r  <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && wready_r) begin
        w_got_r  <= 1'b1;
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (b_done) begin
        w_got_r  <= 1'b0;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r  <= scd_hit(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // divider register; core field reset value from boot option, bus field reset to BUS_RST
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_div_r <= scd_boot_code(low_power_boot_option);
      bus_div_r  <= BUS_RST;
    end else if (ce && wr_do && scd_hit(awaddr_r) && !very_low_power_run) begin
      if (wstrb_r[CORE_LANE]) begin
        core_div_r <= wdata_r[CORE_LSB +: CORE_W];
      end
      if (wstrb_r[BUS_LANE]) begin
        bus_div_r <= wdata_r[BUS_LSB +: BUS_W];
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
    end else if (ce) begin
      if (ar_take) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rresp_r   <= scd_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        rdata_r   <= scd_hit(s_axi_araddr) ? view : '0;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // core/system enable, then bus/flash on top of it
  scd_div #(.W(CORE_W)) u_core_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .tick_in  (1'b1),
    .ratio    (core_div_r),
    .tick_out (core_tick)
  );

  scd_div #(.W(BUS_W)) u_bus_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .tick_in  (core_tick),
    .ratio    (bus_div_r),
    .tick_out (bus_flash_clk_en)
  );

  assign core_clk_en = core_tick;

  a_very_low_power_run_write_block: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_do && very_low_power_run) |=> (core_div_r == $past(core_div_r)) && (bus_div_r == $past(bus_div_r)))
    else $error("divider changed by a write in very low power run");

  a_reset_boot_load: assert property (@(posedge aclk)
    !aresetn |=> core_div_r == scd_boot_code($past(low_power_boot_option)))
    else $error("core ratio not loaded from boot option at reset");

  a_reset_core_code: assert property (@(posedge aclk)
    !aresetn |=> core_div_r inside {4'h0, 4'h1, 4'h3, 4'h7})
    else $error("core ratio after reset not a boot code");

  a_reset_bus_code: assert property (@(posedge aclk)
    !aresetn |=> bus_div_r == BUS_RST)
    else $error("bus ratio after reset is not divide by two");

  a_reserved_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> ((s_axi_rdata & RSV_MASK) == '0))
    else $error("reserved bits read non zero");

  // accepted write to the divider register
  sequence s_reg_write;
    ce && wr_do && scd_hit(awaddr_r) && !very_low_power_run;
  endsequence

  a_core_field_write: assert property (@(posedge aclk) disable iff (!aresetn)
    s_reg_write ##0 wstrb_r[CORE_LANE] |=> core_div_r == wdata_r[CORE_LSB +: CORE_W])
    else $error("core ratio not taken from write data");

  a_bus_field_write: assert property (@(posedge aclk) disable iff (!aresetn)
    s_reg_write ##0 wstrb_r[BUS_LANE] |=> bus_div_r == wdata_r[BUS_LSB +: BUS_W])
    else $error("bus ratio not taken from write data");

  a_ratio_write_only: assert property (@(posedge aclk) disable iff (!aresetn)
    !(ce && wr_do) |=> $stable(core_div_r) && $stable(bus_div_r))
    else $error("divider changed without a write");

  a_read_data_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed before handshake");

endmodule : scd_top
`default_nettype wire

// File: scd_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("FAIL %0t got %h exp %h", $time, g, e); end end
module scd_top_tb_top;
  import scd_pkg::*;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        very_low_power_run, core_clk_en, bus_flash_clk_en;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  s_axi_bresp, s_axi_rresp, low_power_boot_option, rs, fy, fz;
  int          err_total = 0;
  int          n_tests = 0;

  scd_top dut_u (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .low_power_boot_option, .very_low_power_run, .core_clk_en,
    .bus_flash_clk_en);

  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end

  task automatic rst(input logic [1:0] opt);
    @(posedge aclk);
    aresetn <= 0;
    low_power_boot_option <= opt;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
  endtask : rst

  // address and data offered together, each released once taken
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ta, tw, da, dw;
    da = 0;
    dw = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = !da && s_axi_awready === 1'b1;
      tw = !dw && s_axi_wready === 1'b1;
      @(posedge aclk);
      if (ta) begin s_axi_awvalid <= 0; da = 1; end
      if (tw) begin s_axi_wvalid <= 0; dw = 1; end
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 0;
  endtask : rd

  // cycles between two successive enable pulses
  task automatic per(input logic b, output int n);
    do @(negedge aclk); while ((b ? bus_flash_clk_en : core_clk_en) !== 1'b1);
    n = 0;
    do begin @(negedge aclk); n++; end while ((b ? bus_flash_clk_en : core_clk_en) !== 1'b1);
  endtask : per

  // register value, then both periods; second interval avoids the ratio changeover
  task automatic chk(input logic [31:0] e);
    int n;
    rd(CLKDIV1_OFS, rv, rs);
    `CHK(rv, e)
    `CHK(rs, RESP_OKAY)
    per(0, n); per(0, n);
    `CHK(n, e[31:28] + 1)
    per(1, n); per(1, n);
    `CHK(n, (e[31:28] + 1) * (e[18:16] + 1))
  endtask : chk

  task automatic results;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial begin
    #200000;
    err_total++;
    results();
  end

  initial begin
    aresetn = 0; ce = 1; s_axi_awaddr = 0; s_axi_awprot = 0; s_axi_awvalid = 0; s_axi_wdata = 0;
    s_axi_wstrb = 0; s_axi_wvalid = 0; s_axi_bready = 0; s_axi_araddr = 0; s_axi_arprot = 0;
    s_axi_arvalid = 0; s_axi_rready = 0; low_power_boot_option = 0; very_low_power_run = 0;
    for (int i = 0; i < 4; i++) begin
      rst(i[1:0]);
      chk({4'((1 << i) - 1), 9'h0, 3'h1, 16'h0});
    end
    $display("test reset done");
    wr(CLKDIV1_OFS, 32'hFFFF_FFFF, 4'hF, rs);
    `CHK(rs, RESP_OKAY)
    chk(32'hF007_0000);
    wr(CLKDIV1_OFS, 32'h2005_0000, 4'hF, rs);
    chk(32'h2005_0000);
    wr(CLKDIV1_OFS, 32'h7FFF_FFFF, 4'h4, rs);
    chk(32'h2007_0000);
    $display("test write done");
    very_low_power_run <= 1;
    wr(CLKDIV1_OFS, 32'h0000_0000, 4'hF, rs);
    `CHK(rs, RESP_OKAY)
    chk(32'h2007_0000);
    @(posedge aclk) very_low_power_run <= 0;
    $display("test low power done");
    // enable low: both divided enables must hold still
    @(posedge aclk) ce <= 0;
    @(negedge aclk) fz = {core_clk_en, bus_flash_clk_en};
    repeat (8) begin
      @(negedge aclk);
      fy = {core_clk_en, bus_flash_clk_en};
      `CHK(fy, fz)
    end
    @(posedge aclk) ce <= 1;
    chk(32'h2007_0000);
    $display("test enable done");
    wr(16'h1048, 32'h0, 4'hF, rs);
    `CHK(rs, RESP_SLVERR)
    rd(16'h1048, rv, rs);
    `CHK(rs, RESP_SLVERR)
    `CHK(rv, 32'h0)
    chk(32'h2007_0000);
    $display("test unmapped done");
    rst(2'h2);
    chk(32'h3001_0000);
    $display("test second reset done");
    results();
  end
endmodule : scd_top_tb_top
`default_nettype wire
